// *** include/pmul_pkg.sv ***
// Purpose: Shared constants for the 16 x 16 parallel multiplier block
// Assumes: Single system clock, all pins synchronised before use
// Notes: Array positions and widths are named here, never in pmul_array
package pmul_pkg;

  // Operand and product widths
  localparam int OPERAND_W = 16;
  localparam int PRODUCT_W = 32;

  // Input register is data plus its mode bit
  localparam int IN_REG_W = OPERAND_W + 1;
  localparam int IN_MODE_BIT = OPERAND_W;

  // Internal full product width of the signed 17 x 17 array
  localparam int ARRAY_W = 2 * IN_REG_W;

  // Round addends for full and shifted formats
  localparam logic [33:0] ROUND_ADD_FULL = 34'h0_0000_8000;
  localparam logic [33:0] ROUND_ADD_SHIFT = 34'h0_0000_4000;

  // Bit positions used in the format adjust stage
  localparam int FULL_SIGN_POS = 31;
  localparam int SHIFT_TOP_POS = 30;
  localparam int SHIFT_LOW_POS = 15;
  localparam int SHIFT_SUB_POS = 14;
  localparam int SIGN_COPY_POS = 15;

  // Clocking variants
  localparam logic VARIANT_SEP_CLOCKS = 1'b1;
  localparam logic VARIANT_ONE_CLOCK = 1'b0;

  // Depth of pin synchronisers
  localparam int SYNC_STAGES = 2;

endpackage

// *** verilog/pmul_sync.sv ***
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Inputs are asynchronous to sys_clk_i
// Notes: First stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none
module pmul_sync #(
  parameter int WIDTH = 1,
  // Level each stage rests at during reset
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pin levels in and synchronised levels out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  // Metastability catcher, only feeds the second stage
  logic [WIDTH-1:0] meta_reg;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pmul_sync width must be at least one");
    end
  endgenerate

  // Two flip-flops in series per bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_o <= meta_reg;
    end
  end

endmodule // pmul_sync
`default_nettype wire

// *** verilog/pmul_array.sv ***
// Purpose: Combinational multiplier array with round and format adjust
// Assumes: Operands arrive as mode bit over data from input registers
// Notes: Pure logic, no storage; product follows held operands at once
`timescale 1ns/10ps
`default_nettype none
module pmul_array (
  // Held operands, mode bit on top
  input wire logic [pmul_pkg::IN_REG_W-1:0] x_reg_i,
  input wire logic [pmul_pkg::IN_REG_W-1:0] y_reg_i,
  // Held round bit and live format select
  input wire logic round_i,
  input wire logic format_full_i,
  // Product halves before the product registers
  output logic [pmul_pkg::OPERAND_W-1:0] upper_o,
  output logic [pmul_pkg::OPERAND_W-1:0] lower_o
);

  // Operands widened by mode: sign copy or zero
  logic signed [pmul_pkg::IN_REG_W-1:0] x_ext;
  logic signed [pmul_pkg::IN_REG_W-1:0] y_ext;
  // Raw and rounded products
  logic signed [pmul_pkg::ARRAY_W-1:0] raw_prod;
  logic [pmul_pkg::ARRAY_W-1:0] rnd_prod;
  logic [pmul_pkg::ARRAY_W-1:0] rnd_add;

  // Mode bit high means two's complement, per operand
  always_comb
  begin
    x_ext = {x_reg_i[pmul_pkg::IN_MODE_BIT] &
             x_reg_i[pmul_pkg::OPERAND_W-1],
             x_reg_i[pmul_pkg::OPERAND_W-1:0]};
    y_ext = {y_reg_i[pmul_pkg::IN_MODE_BIT] &
             y_reg_i[pmul_pkg::OPERAND_W-1],
             y_reg_i[pmul_pkg::OPERAND_W-1:0]};
    // 17 x 17 signed covers every mixed case exactly
    raw_prod = x_ext * y_ext;
  end

  // Round weight sits at the top of the lower half for each format
  always_comb
  begin
    if (!round_i)
      rnd_add = '0;
    else if (format_full_i)
      rnd_add = pmul_pkg::ROUND_ADD_FULL;
    else
      rnd_add = pmul_pkg::ROUND_ADD_SHIFT;
    rnd_prod = raw_prod + rnd_add;
  end

  // Full product, or left shifted with sign copied into the low half
  always_comb
  begin
    if (format_full_i)
    begin
      upper_o = rnd_prod[pmul_pkg::PRODUCT_W-1:pmul_pkg::OPERAND_W];
      lower_o = rnd_prod[pmul_pkg::OPERAND_W-1:0];
    end
    else
    begin
      upper_o = rnd_prod[pmul_pkg::SHIFT_TOP_POS:pmul_pkg::SHIFT_LOW_POS];
      lower_o = {rnd_prod[pmul_pkg::FULL_SIGN_POS],
                 rnd_prod[pmul_pkg::SHIFT_SUB_POS:0]};
    end
  end

endmodule // pmul_array
`default_nettype wire

// *** verilog/pmul_core.sv ***
// Purpose: 16 x 16 clocked parallel multiplier with output steering
// Assumes: All pins asynchronous; sampled through two flip-flops
// Notes: Pin clocks of the separate-clock variant become edge strobes
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Multiply two 16-bit operands, full 32-bit product
// - Each operand held with mode bit, 17 bits
// - Mode high signed, low unsigned, per operand
// - Two 16-bit product registers, upper and lower
// - Bypass high reloads both product registers every cycle
// - Format high full product, low shifted 31-bit
// - Round adds one at lower half top bit
// - Select low: upper on main, lower shared
// - Select high: lower half on both ports
// - Shared port floats while its enable high
// - Main port driven while its enable low
// - Lower half reaches shared port separately
// - X clock edge loads X, mode, round
// - Y clock edge loads Y, mode, round
// - Upper register loads on its own clock
// - Lower register loads on its own clock
// - One clock loads every enabled register
// - X enable low loads, high holds
// - Y enable loads or holds likewise
// - One product enable loads both halves
// - Round captured when either input clocks
// - Shifted format copies sign to bit 15
module pmul_core #(
  parameter logic SEP_CLOCKS = pmul_pkg::VARIANT_SEP_CLOCKS
) (
  // System clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // X operand pins
  input wire logic [pmul_pkg::OPERAND_W-1:0] x_data_i,
  input wire logic x_signed_sel_i,
  // Shared Y input / lower product port, input side
  input wire logic [pmul_pkg::OPERAND_W-1:0] shared_port_in_i,
  input wire logic y_signed_sel_i,
  // Product controls
  input wire logic round_ctl_i,
  input wire logic product_bypass_i,
  input wire logic product_format_sel_i,
  input wire logic output_half_sel_i,
  // Output enables, both active low
  input wire logic shared_port_out_en_n_i,
  input wire logic main_port_out_en_n_i,
  // Separate-clock variant register clocks
  input wire logic x_reg_clock_i,
  input wire logic y_reg_clock_i,
  input wire logic upper_product_clock_i,
  input wire logic lower_product_clock_i,
  // Single-clock variant register enables, active low
  input wire logic x_load_en_n_i,
  input wire logic y_load_en_n_i,
  input wire logic product_load_en_n_i,
  // Main output port
  output logic [pmul_pkg::OPERAND_W-1:0] main_port_out_o,
  output logic main_port_oe_o,
  // Shared port, output side
  output logic [pmul_pkg::OPERAND_W-1:0] shared_port_out_o,
  output logic shared_port_oe_o
);

  localparam int W = pmul_pkg::OPERAND_W;
  // Width of the synchronised pin bundle
  localparam int PIN_W = 2 * W + 15;
  // Active-low enables rest high in reset, so nothing drives or loads
  // before the synchroniser has filled with real pin levels
  localparam logic [PIN_W-1:0] PIN_RST = {{(2 * W + 6){1'b0}}, 2'h3, 4'h0,
                                          3'h7};

  generate
    if (W != 16)
    begin : g_bad_width
      $error("pmul_core is built for 16-bit operands only");
    end
  endgenerate

  // Raw pin bundle and its synchronised copy
  logic [PIN_W-1:0] pin_bus;
  logic [PIN_W-1:0] pin_sync;

  // Synchronised pin levels
  logic [W-1:0] x_data_s;
  logic [W-1:0] y_data_s;
  logic x_sgn_s;
  logic y_sgn_s;
  logic round_s;
  logic bypass_s;
  logic format_s;
  logic half_sel_s;
  logic sh_en_n_s;
  logic mn_en_n_s;
  logic x_clk_s;
  logic y_clk_s;
  logic up_clk_s;
  logic lo_clk_s;
  logic x_en_n_s;
  logic y_en_n_s;
  logic p_en_n_s;

  // Previous clock pin levels for edge detection
  logic x_clk_prev_reg;
  logic y_clk_prev_reg;
  logic up_clk_prev_reg;
  logic lo_clk_prev_reg;

  // Load strobes for each register
  logic x_load;
  logic y_load;
  logic up_load;
  logic lo_load;

  // Input registers, mode bit on top
  logic [pmul_pkg::IN_REG_W-1:0] x_reg;
  logic [pmul_pkg::IN_REG_W-1:0] y_reg;
  logic round_reg;

  // Array outputs and product registers
  logic [W-1:0] arr_upper;
  logic [W-1:0] arr_lower;
  logic [W-1:0] upper_product_reg;
  logic [W-1:0] lower_product_reg;

  // Gather all pins so one synchroniser serves them
  assign pin_bus = {x_data_i, shared_port_in_i, x_signed_sel_i,
                    y_signed_sel_i, round_ctl_i, product_bypass_i,
                    product_format_sel_i, output_half_sel_i,
                    shared_port_out_en_n_i, main_port_out_en_n_i,
                    x_reg_clock_i, y_reg_clock_i, upper_product_clock_i,
                    lower_product_clock_i, x_load_en_n_i, y_load_en_n_i,
                    product_load_en_n_i};

  // Two flip-flops on every pin before any logic
  pmul_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin_bus),
    .sync_o(pin_sync)
  );

  // Unpack in the same order as packed
  assign {x_data_s, y_data_s, x_sgn_s, y_sgn_s, round_s, bypass_s,
          format_s, half_sel_s, sh_en_n_s, mn_en_n_s, x_clk_s, y_clk_s,
          up_clk_s, lo_clk_s, x_en_n_s, y_en_n_s, p_en_n_s} = pin_sync;

  // Remember last clock pin levels to find rising edges
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      x_clk_prev_reg <= 1'b0;
      y_clk_prev_reg <= 1'b0;
      up_clk_prev_reg <= 1'b0;
      lo_clk_prev_reg <= 1'b0;
    end
    else
    begin
      x_clk_prev_reg <= x_clk_s;
      y_clk_prev_reg <= y_clk_s;
      up_clk_prev_reg <= up_clk_s;
      lo_clk_prev_reg <= lo_clk_s;
    end
  end

  // Choose edge strobes or enables by variant
  // Pin clocks must stay below half sys_clk_i or edges are missed
  always_comb
  begin
    if (SEP_CLOCKS)
    begin
      x_load = x_clk_s & ~x_clk_prev_reg;
      y_load = y_clk_s & ~y_clk_prev_reg;
      up_load = up_clk_s & ~up_clk_prev_reg;
      lo_load = lo_clk_s & ~lo_clk_prev_reg;
    end
    else
    begin
      // Every enabled register loads on the common edge
      x_load = ~x_en_n_s;
      y_load = ~y_en_n_s;
      up_load = ~p_en_n_s;
      lo_load = ~p_en_n_s;
    end
  end

  // X register with its mode bit, holds otherwise
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      x_reg <= '0;
    else if (x_load)
      x_reg <= {x_sgn_s, x_data_s};
  end

  // Y register, fed from the shared port input side
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      y_reg <= '0;
    else if (y_load)
      y_reg <= {y_sgn_s, y_data_s};
  end

  // Round bit follows whichever input register clocks
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      round_reg <= 1'b0;
    else if (x_load || y_load)
      round_reg <= round_s;
  end

  // Signed array with round and format, no storage inside
  pmul_array u_array (
    .x_reg_i(x_reg),
    .y_reg_i(y_reg),
    .round_i(round_reg),
    .format_full_i(format_s),
    .upper_o(arr_upper),
    .lower_o(arr_lower)
  );

  // Upper product register; bypass loads every cycle
  // Bypass still costs one register stage at sys_clk_i
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      upper_product_reg <= '0;
    else if (bypass_s || up_load)
      upper_product_reg <= arr_upper;
  end

  // Lower product register; bypass loads every cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lower_product_reg <= '0;
    else if (bypass_s || lo_load)
      lower_product_reg <= arr_lower;
  end

  // Main port multiplexer and its active-low enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      main_port_out_o <= '0;
      main_port_oe_o <= 1'b0;
    end
    else
    begin
      if (half_sel_s)
        main_port_out_o <= lower_product_reg;
      else
        main_port_out_o <= upper_product_reg;
      main_port_oe_o <= ~mn_en_n_s;
    end
  end

  // Shared port buffer, lower half only, apart from the mux
  // Host must hold the shared enable high, so the device floats the wire, while it drives Y data
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shared_port_out_o <= '0;
      shared_port_oe_o <= 1'b0;
    end
    else
    begin
      shared_port_out_o <= lower_product_reg;
      shared_port_oe_o <= ~sh_en_n_s;
    end
  end

  // Checks

  // A load strobe followed by the next cycle
  sequence s_x_load;
    x_load ##1 1'b1;
  endsequence

  sequence s_y_load;
    y_load ##1 1'b1;
  endsequence

  chk_x_capture: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_x_load |-> x_reg == $past({x_sgn_s, x_data_s}))
    else $error("X register missed its load");

  chk_y_capture: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_y_load |-> y_reg == $past({y_sgn_s, y_data_s}))
    else $error("Y register missed its load");

  chk_x_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !x_load |=> $stable(x_reg))
    else $error("X register changed without load");

  chk_round_capture: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (x_load || y_load) |=> round_reg == $past(round_s))
    else $error("Round bit not captured with input");

  chk_unsigned_full: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (!x_reg[pmul_pkg::IN_MODE_BIT] && !y_reg[pmul_pkg::IN_MODE_BIT] &&
     !round_reg && format_s) |->
    {arr_upper, arr_lower} ==
      32'(x_reg[W-1:0]) * 32'(y_reg[W-1:0]))
    else $error("Unsigned full product wrong");

  chk_bypass_pass: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    bypass_s |=> upper_product_reg == $past(arr_upper) &&
                 lower_product_reg == $past(arr_lower))
    else $error("Bypass did not pass product");

  chk_product_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (!bypass_s && !up_load) |=> $stable(upper_product_reg))
    else $error("Upper product changed without load");

  chk_main_mux: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    1'b1 |=> main_port_out_o == ($past(half_sel_s) ?
      $past(lower_product_reg) : $past(upper_product_reg)))
    else $error("Main port shows wrong half");

  chk_port_enables: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    1'b1 |=> shared_port_oe_o == !$past(sh_en_n_s) &&
             main_port_oe_o == !$past(mn_en_n_s))
    else $error("Port enable does not follow control");

  chk_sign_copy: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (!format_s && !round_reg && x_reg[pmul_pkg::IN_MODE_BIT] &&
     y_reg[pmul_pkg::IN_MODE_BIT] && x_reg[W-1] && !y_reg[W-1] &&
     y_reg[W-2:0] != '0) |->
    arr_lower[pmul_pkg::SIGN_COPY_POS])
    else $error("Sign bit not copied into lower half");

endmodule // pmul_core
`default_nettype wire

// *** verification/pmul_host.sv ***
// Purpose: Host model on the shared Y input / lower product wire
// Assumes: Device drives the wire only while its enable output is high
// Notes: An undriven wire shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module pmul_host (
  // Clock
  input wire logic sys_clk_i,
  // Host operand and drive request
  input wire logic [15:0] y_val_i,
  input wire logic y_drive_i,
  // Device side of the shared port
  input wire logic [15:0] dev_out_i,
  input wire logic dev_oe_i,
  // Resolved wire level
  output logic [15:0] wire_o
);
  // Last level seen on the wire
  logic [15:0] last_reg = 16'h0000;
  // Tracked so a floating wire never looks like held data
  always_ff @(posedge sys_clk_i)
  begin
    last_reg <= wire_o;
  end
  // Wire resolution; a clash goes unknown so any check on the wire fails
  always_comb
  begin
    if (dev_oe_i && y_drive_i)
      wire_o = 16'hXXXX;
    else if (dev_oe_i)
      wire_o = dev_out_i;
    else if (y_drive_i)
      wire_o = y_val_i;
    else
      wire_o = ~last_reg;
  end
endmodule // pmul_host
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for both clocking variants side by side
// Assumes: Pins pass two sync flops, so loads land three edges later
// Notes: Both variants see the same pins and must give equal results
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // Clock, reset and counters
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  // Pins shared by both variants
  logic [15:0] x_data = 16'h0000;
  logic [15:0] y_val = 16'h0000;
  logic y_drive = 1'b0;
  logic x_sel = 1'b0;
  logic y_sel = 1'b0;
  logic round_ctl = 1'b0;
  logic bypass = 1'b0;
  logic fmt_sel = 1'b1;
  logic half_sel = 1'b0;
  logic sh_en_n = 1'b1;
  logic main_en_n = 1'b0;
  logic x_clk = 1'b0;
  logic y_clk = 1'b0;
  logic up_clk = 1'b0;
  logic lo_clk = 1'b0;
  logic x_en_n = 1'b1;
  logic y_en_n = 1'b1;
  logic p_en_n = 1'b1;
  // Per-variant results, index 0 single clock, 1 separate clocks
  logic [15:0] main_o [2];
  logic moe [2];
  logic [15:0] sh_o [2];
  logic soe [2];
  logic [15:0] sh_w [2];
  logic [31:0] last_p;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // One device and one host per variant
  for (genvar v = 0; v < 2; v++)
  begin : g_var
    pmul_core #(.SEP_CLOCKS(v == 1)) pmul_core_inst (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .x_data_i(x_data),
      .x_signed_sel_i(x_sel), .shared_port_in_i(sh_w[v]),
      .y_signed_sel_i(y_sel), .round_ctl_i(round_ctl),
      .product_bypass_i(bypass), .product_format_sel_i(fmt_sel),
      .output_half_sel_i(half_sel), .shared_port_out_en_n_i(sh_en_n),
      .main_port_out_en_n_i(main_en_n), .x_reg_clock_i(x_clk),
      .y_reg_clock_i(y_clk), .upper_product_clock_i(up_clk),
      .lower_product_clock_i(lo_clk), .x_load_en_n_i(x_en_n),
      .y_load_en_n_i(y_en_n), .product_load_en_n_i(p_en_n),
      .main_port_out_o(main_o[v]), .main_port_oe_o(moe[v]),
      .shared_port_out_o(sh_o[v]), .shared_port_oe_o(soe[v]));
    pmul_host pmul_host_inst (
      .sys_clk_i(sys_clk), .y_val_i(y_val), .y_drive_i(y_drive),
      .dev_out_i(sh_o[v]), .dev_oe_i(soe[v]), .wire_o(sh_w[v]));
  end
  // Verdict and end of run
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far above the two hundred or so cycles needed
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // Data compare
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // Inputs change one nanosecond after the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Reference product from operands, modes, round and format
  function automatic logic [31:0] exp_prod(input logic [15:0] x, y,
    input logic xs, ys, rnd, fmt);
    logic [33:0] a;
    logic [33:0] b;
    logic [33:0] p;
    a = {{18{xs & x[15]}}, x};
    b = {{18{ys & y[15]}}, y};
    p = a * b;
    if (rnd)
      p = p + (fmt ? pmul_pkg::ROUND_ADD_FULL : pmul_pkg::ROUND_ADD_SHIFT);
    return fmt ? p[31:0] : {p[30:15], p[31], p[14:0]};
  endfunction
  // One operation: Y driven by host, then port handed to the device
  task automatic run_op(input logic [15:0] x, y,
    input logic xs, ys, rnd, fmt, ldin, ldp);
    step(1);
    // Device must release the wire before the host drives Y onto it
    sh_en_n = 1'b1;
    step(3);
    x_data = x;
    y_val = y;
    y_drive = 1'b1;
    x_sel = xs;
    y_sel = ys;
    round_ctl = rnd;
    fmt_sel = fmt;
    x_en_n = !ldin;
    y_en_n = !ldin;
    p_en_n = !ldp;
    x_clk = ldin;
    y_clk = ldin;
    step(3);
    x_clk = 1'b0;
    y_clk = 1'b0;
    step(3);
    x_en_n = 1'b1;
    y_en_n = 1'b1;
    y_drive = 1'b0;
    sh_en_n = 1'b0;
    up_clk = ldp;
    lo_clk = ldp;
    step(3);
    up_clk = 1'b0;
    lo_clk = 1'b0;
    p_en_n = 1'b1;
    step(6);
  endtask
  // Both ports of both variants
  task automatic check_out(input logic [15:0] em, input logic [15:0] el);
    for (int v = 0; v < 2; v++)
    begin
      cmp16(main_o[v], em);
      cmp16(sh_w[v], el);
    end
  endtask
  // Drive enables of both variants
  task automatic check_oe(input logic m, input logic s);
    for (int v = 0; v < 2; v++)
    begin
      cmp1(moe[v], m);
      cmp1(soe[v], s);
    end
  endtask
  // Mode, round and format table; shifted format only when both signed
  task automatic t_modes();
    logic [15:0] xv [6] = '{16'hFFFF, 16'hFFFF, 16'h8000, 16'h8000,
      16'h1234, 16'hC000};
    logic [15:0] yv [6] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h8000,
      16'h5678, 16'h4000};
    logic [3:0] cv [6] = '{4'h1, 4'hD, 4'h9, 4'hE, 4'h7, 4'hC};
    for (int i = 0; i < 6; i++)
    begin
      run_op(xv[i], yv[i], cv[i][3], cv[i][2], cv[i][1], cv[i][0], 1, 1);
      last_p = exp_prod(xv[i], yv[i], cv[i][3], cv[i][2], cv[i][1],
        cv[i][0]);
      check_out(last_p[31:16], last_p[15:0]);
    end
  endtask
  // No load at all, then product load over held operands and round
  task automatic t_hold();
    run_op(16'h0101, 16'h0202, 1, 1, 0, 0, 0, 0);
    check_out(last_p[31:16], last_p[15:0]);
    // Round pin high but not captured; full format makes the load visible
    run_op(16'h0303, 16'h0404, 1, 1, 1, 1, 0, 1);
    last_p = exp_prod(16'hC000, 16'h4000, 1, 1, 0, 1);
    check_out(last_p[31:16], last_p[15:0]);
  endtask
  // Bypass reloads product registers without any product load
  task automatic t_bypass();
    bypass = 1'b1;
    run_op(16'h0007, 16'h0009, 0, 0, 1, 1, 1, 0);
    last_p = exp_prod(16'h0007, 16'h0009, 0, 0, 1, 1);
    check_out(last_p[31:16], last_p[15:0]);
    bypass = 1'b0;
    step(1);
  endtask
  // Lower half on both ports, then back to upper on the main port
  task automatic t_sel();
    half_sel = 1'b1;
    step(4);
    check_out(last_p[15:0], last_p[15:0]);
    half_sel = 1'b0;
    step(4);
    check_out(last_p[31:16], last_p[15:0]);
  endtask
  // Each enable floats only its own port
  task automatic t_oe();
    main_en_n = 1'b1;
    step(4);
    check_oe(1'b0, 1'b1);
    main_en_n = 1'b0;
    sh_en_n = 1'b1;
    step(4);
    check_oe(1'b1, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_modes();
    t_hold();
    t_bypass();
    t_sel();
    t_oe();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
